// file: common/bsi_pkg.sv
/*
  Constants, types and fixed reply images for the boot serial inquiry and
  setting command interpreter.
  Assumes a byte-wide receive and transmit stream on a single 10 MHz clock.
*/
package bsi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command and reply codes; each inquiry reply code is its command code plus 10h
  // Data area reply code is pinned by its fixed check byte of 8Dh
  localparam logic [7:0] CMD_DEVICES = 8'h20;
  localparam logic [7:0] CMD_AVAIL   = 8'h2A;
  localparam logic [7:0] CMD_UAREA   = 8'h2C;
  localparam logic [7:0] CMD_DAREA   = 8'h2B;
  localparam logic [7:0] CMD_BLOCK   = 8'h2D;
  localparam logic [7:0] CMD_DEVSEL  = 8'h10;
  localparam logic [7:0] CMD_FREQ    = 8'h3F;
  localparam logic [7:0] RSP_DEVICES = 8'h30;
  localparam logic [7:0] RSP_AVAIL   = 8'h3A;
  localparam logic [7:0] RSP_UAREA   = 8'h3C;
  localparam logic [7:0] RSP_DAREA   = 8'h3B;
  localparam logic [7:0] RSP_BLOCK   = 8'h3D;
  localparam logic [7:0] ACK_DEV     = 8'h46;
  localparam logic [7:0] ACK_OK      = 8'h06;
  localparam logic [7:0] RSP_UNDEF   = 8'h80;
  localparam logic [7:0] ERR_FLAG    = 8'h80;
  localparam logic [7:0] ERR_SUM     = 8'h11;
  localparam logic [7:0] ERR_DEV     = 8'h21;
  localparam logic [7:0] ERR_RATE    = 8'h24;
  localparam logic [7:0] ERR_CONFIRM = 8'hFF;
  localparam logic [7:0] SIZE_DEVSEL = 8'h04;
  localparam logic [7:0] SIZE_FREQ   = 8'h07;
  localparam logic [7:0] AVAIL_SUM   = 8'hA8;
  localparam logic [7:0] DAREA_SUM   = 8'h8D;

  ////////////////////////////////////////////////////////////////////////////
  // Device records; codes and names are arbitrary values
  localparam logic [31:0] DEV_CODE_LE = 32'h4445_564C;
  localparam logic [31:0] DEV_CODE_BE = 32'h4445_5642;
  localparam logic [31:0] NAME_LE     = 32'h5345_524C;
  localparam logic [31:0] NAME_BE     = 32'h5345_5242;
  localparam logic [7:0]  DEV_COUNT   = 8'h02;
  localparam logic [7:0]  REC_CHARS   = 8'h08;
  localparam logic [7:0]  BLK_MARK    = 8'hDD;

  // Memory layout; user area figures are plain defaults
  localparam logic [31:0] USER_START  = 32'hFFFF_C000;
  localparam logic [31:0] USER_END    = 32'hFFFF_FFFF;
  localparam logic [31:0] USER_BLOCKS = 32'h0000_0010;
  localparam logic [31:0] DATA_START  = 32'h0010_0000;
  localparam logic [31:0] DATA_END    = 32'h0010_0FFF;
  localparam logic [31:0] BLOCK_SIZE  = 32'h0000_0400;
  localparam logic [31:0] DATA_BLOCKS = 32'h0000_0004;

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate check
  localparam int          BAUD_UNIT   = 100;
  localparam int          OVERSAMPLE  = 32;
  localparam int          HZ_PER_MHZ  = 1000000;
  localparam int          REF_HI_MHZ  = 32;
  localparam int          REF_LO_MHZ  = 8;
  localparam int          TOL_PCT     = 4;
  localparam logic [25:0] REF_HI_HZ   = 26'(REF_HI_MHZ * HZ_PER_MHZ);
  localparam logic [25:0] REF_LO_HZ   = 26'(REF_LO_MHZ * HZ_PER_MHZ);
  localparam logic [11:0] RATE_SCALE  = 12'(OVERSAMPLE * BAUD_UNIT);
  localparam logic [7:0]  TOL_SCALE   = 8'(100 / TOL_PCT + 1);
  localparam logic [9:0]  N_MAX       = 10'h100;
  localparam logic [8:0]  BAUD_N_RST  = 9'h000;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    REP_DEVICES, REP_AVAIL, REP_UAREA, REP_DAREA, REP_BLOCK, REP_NONE
  } bsi_rep_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_CALC, ST_FETCH, ST_LATCH, ST_SEND, ST_CONFIRM
  } bsi_state_type;

  // Reply images, left aligned in 32 bytes, checksum appended on the fly
  localparam logic [255:0] IMG_DEVICES = {RSP_DEVICES, 8'h13, DEV_COUNT,
    REC_CHARS, DEV_CODE_LE, NAME_LE, REC_CHARS, DEV_CODE_BE, NAME_BE, 88'h0};
  localparam logic [255:0] IMG_AVAIL = {RSP_AVAIL, 8'h01, 8'h1D, 232'h0};
  localparam logic [255:0] IMG_UAREA = {RSP_UAREA, 8'h09, 8'h01,
    USER_START, USER_END, 168'h0};
  localparam logic [255:0] IMG_DAREA = {RSP_DAREA, 8'h09, 8'h01,
    DATA_START, DATA_END, 168'h0};
  localparam logic [255:0] IMG_BLOCK = {RSP_BLOCK, 16'h0019, BLK_MARK,
    USER_START, BLOCK_SIZE, USER_BLOCKS, DATA_START, BLOCK_SIZE,
    DATA_BLOCKS, 32'h0};

  function automatic bsi_rep_type bsi_decode(input logic [7:0] code);
    case (code)
      CMD_DEVICES: bsi_decode = REP_DEVICES;
      CMD_AVAIL:   bsi_decode = REP_AVAIL;
      CMD_UAREA:   bsi_decode = REP_UAREA;
      CMD_DAREA:   bsi_decode = REP_DAREA;
      CMD_BLOCK:   bsi_decode = REP_BLOCK;
      default:     bsi_decode = REP_NONE;
    endcase
  endfunction : bsi_decode

  // Bytes of a reply before its checksum
  function automatic logic [4:0] bsi_rep_len(input bsi_rep_type r);
    case (r)
      REP_DEVICES: bsi_rep_len = 5'h15;
      REP_AVAIL:   bsi_rep_len = 5'h03;
      REP_UAREA:   bsi_rep_len = 5'h0B;
      REP_DAREA:   bsi_rep_len = 5'h0B;
      REP_BLOCK:   bsi_rep_len = 5'h1C;
      default:     bsi_rep_len = 5'h01;
    endcase
  endfunction : bsi_rep_len

endpackage : bsi_pkg

// file: src/bsi_rom.sv
/*
  Reply image memory: one byte of a fixed inquiry reply per index.
  Assumes the caller waits one clock for the registered read data.
*/
`timescale 1ns/10ps
`default_nettype none

module bsi_rom
  import bsi_pkg::*;
(
  input  wire logic        i_clk,    // System clock
  input  wire logic        i_arst_n, // Async reset, active low
  input  wire bsi_rep_type i_sel,    // Reply image select
  input  wire logic [4:0]  i_idx,    // Byte index in image
  output logic      [7:0]  o_byte    // Registered byte
);

  logic [255:0] img;

  always_comb
  begin
    case (i_sel)
      REP_DEVICES: img = IMG_DEVICES;
      REP_AVAIL:   img = IMG_AVAIL;
      REP_UAREA:   img = IMG_UAREA;
      REP_DAREA:   img = IMG_DAREA;
      REP_BLOCK:   img = IMG_BLOCK;
      default:     img = '0;
    endcase
  end

  // Index 0 is the top byte of the image
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_byte <= 8'h00;
    else
      o_byte <= img[{~i_idx, 3'b000} +: 8];
  end

endmodule : bsi_rom

`default_nettype wire

// file: src/bsi_interp.sv
/*
  Inquiry and setting command interpreter for the serial boot link.
  Assumes a byte receiver and transmitter on the same clock, and an outer
  boot sequencer that raises i_cmd_wait in the command wait state.
*/
// Contract
// - Inquiries are taken only while the command wait state is active.
// - Device inquiry 20h answers 30h, size, count 02h, little then big.
// - Each record: char count, 4-byte device code, ASCII series name.
// - Availability reply: size 01h, value 1Dh, check A8h.
// - User area reply: size 09h, count 01h, start and end addresses.
// - Data area reply: size 09h, count 01h, 0010_0000h..0010_0FFFh, 8Dh.
// - Block reply: size 0019h, user and data start, 1 KB, block counts.
// - Multi-byte frames sum to zero modulo 256, dummies included.
// - Settings are taken only while the command wait state is active.
// - Valid supported device code with good check gets 46h.
// - Bad check gives error 11h, unknown device gives error 21h.
// - Rate field is bits per second divided by 100.
// - N is ref/(32*rate) truncated; ref 32 MHz at high supply else 8.
// - Supportable rate answers 06h; error 4% or more or bad check fails.
// - Device switches rate; good confirmation 06h, otherwise error.
// - Excess rate error reports error code 24h.
// - Size counts payload only, not code, size or check byte.
// - Undefined command gets 80h followed by the received code.
`timescale 1ns/10ps
`default_nettype none

module bsi_interp
  import bsi_pkg::*;
(
  input  wire logic       i_clk,         // System clock, 10 MHz
  input  wire logic       i_arst_n,      // Async reset, active low
  input  wire logic       i_cmd_wait,    // Command wait state active
  input  wire logic       i_volt_high,   // Supply at or above 3.0 V, pin
  input  wire logic       i_rx_valid,    // Received byte strobe
  input  wire logic [7:0] i_rx_data,     // Received byte
  input  wire logic       i_rx_err,      // Received byte is corrupt
  output logic            o_tx_valid,    // Transmit byte valid
  output logic      [7:0] o_tx_data,     // Transmit byte
  input  wire logic       i_tx_ready,    // Transmitter takes byte
  output logic            o_rate_switch, // Pulse: apply o_baud_n now
  output logic      [8:0] o_baud_n,      // Divider N for new rate
  output logic            o_dev_selected,// A device code was accepted
  output logic            o_big_endian   // Selected code is big endian
);

  bsi_state_type st;
  bsi_rep_type   rep;
  logic [7:0]  cmd, size, cnt, rx_sum, frame_total, tx_sum, tx_second;
  logic [55:0] payload;
  logic [25:0] rem, ref_hz;
  logic [27:0] dvs;
  logic [9:0]  quo;
  logic [4:0]  tx_idx;
  logic [7:0]  rom_byte, sh_b0, sh_b1, tx_byte;
  logic        have_size, tx_last, short_two, confirm_pending;
  logic        v_meta, v_mid, v_late, volt_high;
  logic        frame_end, code_ok, go_calc, calc_done, calc_ok;
  logic        take_cmd, done, sh_go, sh_two;

  ////////////////////////////////////////////////////////////////////////////
  // Supply level pin: three stages, accepted once the last two agree
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      v_meta    <= 1'b0;
      v_mid     <= 1'b0;
      v_late    <= 1'b0;
      volt_high <= 1'b0;
    end
    else
    begin
      v_meta <= i_volt_high;
      v_mid  <= v_meta;
      v_late <= v_mid;
      if (v_mid == v_late)
        volt_high <= v_late;
    end
  end

  assign ref_hz      = volt_high ? REF_HI_HZ : REF_LO_HZ;
  assign take_cmd    = (st == ST_IDLE) && i_rx_valid && i_cmd_wait;
  assign frame_total = rx_sum + i_rx_data;
  assign frame_end   = (st == ST_RECV) && i_rx_valid && have_size &&
                       (cnt == 8'h00);
  assign code_ok     = (size == SIZE_DEVSEL) &&
                       ((payload[31:0] == DEV_CODE_LE) ||
                        (payload[31:0] == DEV_CODE_BE));
  assign go_calc     = frame_end && (frame_total == 8'h00) &&
                       (cmd == CMD_FREQ) && (size == SIZE_FREQ);
  // Stop at N_MAX+1 so the loop is bounded for very low rates
  assign calc_done   = (st == ST_CALC) && ((dvs == 28'h0) ||
                       ({2'b00, rem} < dvs) || (quo > N_MAX));
  // Error below 4% reduces to 26*remainder < reference, no divide needed
  assign calc_ok     = (dvs != 28'h0) && (quo != 10'h0) && (quo <= N_MAX) &&
                       (34'(TOL_SCALE) * 34'(rem) < 34'(ref_hz));
  assign o_tx_valid  = (st == ST_SEND);
  assign o_tx_data   = tx_byte;
  assign done        = (st == ST_SEND) && i_tx_ready &&
                       ((rep == REP_NONE) ? !short_two : tx_last);

  ////////////////////////////////////////////////////////////////////////////
  // Short replies: acknowledges and two-byte errors
  always_comb
  begin
    sh_go  = 1'b0;
    sh_two = 1'b1;
    sh_b0  = cmd | ERR_FLAG;
    sh_b1  = ERR_SUM;
    case (st)
      ST_IDLE:
        if (take_cmd && (bsi_decode(i_rx_data) == REP_NONE) &&
            (i_rx_data != CMD_DEVSEL) && (i_rx_data != CMD_FREQ))
        begin
          sh_go = 1'b1;
          sh_b0 = RSP_UNDEF;
          sh_b1 = i_rx_data;
        end
      ST_RECV:
        if (frame_end && !go_calc)
        begin
          sh_go = 1'b1;
          if (frame_total != 8'h00)
            sh_b1 = ERR_SUM;
          else if (cmd == CMD_FREQ)
            sh_b1 = ERR_RATE;
          else if (code_ok)
          begin
            sh_b0  = ACK_DEV;
            sh_two = 1'b0;
          end
          else
            sh_b1 = ERR_DEV;
        end
      ST_CALC:
        if (calc_done)
        begin
          sh_go  = 1'b1;
          sh_two = !calc_ok;
          sh_b0  = calc_ok ? ACK_OK : (cmd | ERR_FLAG);
          sh_b1  = ERR_RATE;
        end
      ST_CONFIRM:
        if (i_rx_valid)
        begin
          sh_go  = 1'b1;
          sh_two = i_rx_err;
          sh_b0  = i_rx_err ? (cmd | ERR_FLAG) : ACK_OK;
          sh_b1  = ERR_CONFIRM;
        end
      default:
        sh_go = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st              <= ST_IDLE;
      rep             <= REP_NONE;
      confirm_pending <= 1'b0;
    end
    else
    begin
      if (sh_go)
        rep <= REP_NONE;
      case (st)
        ST_IDLE:
          if (take_cmd)
          begin
            if (bsi_decode(i_rx_data) != REP_NONE)
            begin
              rep <= bsi_decode(i_rx_data);
              st  <= ST_FETCH;
            end
            else if (sh_go)
              st <= ST_SEND;
            else
              st <= ST_RECV;
          end
        ST_RECV:
          if (frame_end)
            st <= go_calc ? ST_CALC : ST_SEND;
        ST_CALC:
          if (calc_done)
          begin
            st              <= ST_SEND;
            confirm_pending <= calc_ok;
          end
        ST_FETCH:
          st <= ST_LATCH;
        ST_LATCH:
          st <= ST_SEND;
        ST_SEND:
          if (done)
          begin
            st              <= confirm_pending ? ST_CONFIRM : ST_IDLE;
            confirm_pending <= 1'b0;
          end
          else if (i_tx_ready && (rep != REP_NONE) && !tx_last &&
                   (tx_idx != bsi_rep_len(rep) - 5'h01))
            st <= ST_FETCH;
        ST_CONFIRM:
          if (i_rx_valid)
            st <= ST_SEND;
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command framing: size counts payload bytes only
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cmd       <= 8'h00;
      size      <= 8'h00;
      cnt       <= 8'h00;
      rx_sum    <= 8'h00;
      payload   <= '0;
      have_size <= 1'b0;
    end
    else if (take_cmd)
    begin
      cmd       <= i_rx_data;
      rx_sum    <= i_rx_data;
      have_size <= 1'b0;
    end
    else if ((st == ST_RECV) && i_rx_valid)
    begin
      if (!have_size)
      begin
        size      <= i_rx_data;
        cnt       <= i_rx_data;
        have_size <= 1'b1;
        rx_sum    <= frame_total;
      end
      else if (cnt != 8'h00)
      begin
        payload <= {payload[47:0], i_rx_data};
        cnt     <= cnt - 8'h01;
        rx_sum  <= frame_total;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider search by repeated subtraction, at most 258 cycles
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rem <= 26'h0;
      dvs <= 28'h0;
      quo <= 10'h0;
    end
    else if (go_calc)
    begin
      rem <= ref_hz;
      dvs <= 28'(payload[55:40]) * 28'(RATE_SCALE);
      quo <= 10'h0;
    end
    else if ((st == ST_CALC) && !calc_done)
    begin
      rem <= rem - dvs[25:0];
      quo <= quo + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit byte and running checksum
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_byte   <= 8'h00;
      tx_second <= 8'h00;
      short_two <= 1'b0;
      tx_idx    <= 5'h00;
      tx_sum    <= 8'h00;
      tx_last   <= 1'b0;
    end
    else if (sh_go)
    begin
      tx_byte   <= sh_b0;
      tx_second <= sh_b1;
      short_two <= sh_two;
    end
    else if (take_cmd)
    begin
      tx_idx  <= 5'h00;
      tx_sum  <= 8'h00;
      tx_last <= 1'b0;
    end
    else if (st == ST_LATCH)
      tx_byte <= rom_byte;
    else if ((st == ST_SEND) && i_tx_ready)
    begin
      if (rep == REP_NONE)
      begin
        tx_byte   <= tx_second;
        short_two <= 1'b0;
      end
      else if (!tx_last)
      begin
        tx_sum <= tx_sum + tx_byte;
        if (tx_idx == bsi_rep_len(rep) - 5'h01)
        begin
          tx_byte <= 8'h00 - (tx_sum + tx_byte);
          tx_last <= 1'b1;
        end
        else
          tx_idx <= tx_idx + 5'h01;
      end
    end
  end

  bsi_rom u_rom (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_sel    (rep),
    .i_idx    (tx_idx),
    .o_byte   (rom_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Settings that leave the block
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rate_switch  <= 1'b0;
      o_baud_n       <= BAUD_N_RST;
      o_dev_selected <= 1'b0;
      o_big_endian   <= 1'b0;
    end
    else
    begin
      // Switch only after the acceptance byte has left at the old rate
      o_rate_switch <= done && confirm_pending;
      if (done && confirm_pending)
        o_baud_n <= quo[8:0];
      if (frame_end && (frame_total == 8'h00) && (cmd == CMD_DEVSEL) &&
          code_ok)
      begin
        o_dev_selected <= 1'b1;
        o_big_endian   <= (payload[31:0] == DEV_CODE_BE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  property p_ignore_outside;
    (st == ST_IDLE && i_rx_valid && !i_cmd_wait) |=> (st == ST_IDLE);
  endproperty
  a_ignore_outside: assert property (p_ignore_outside)
    else $error("byte taken outside command wait state");

  property p_dev_first;
    (st == ST_LATCH && rep == REP_DEVICES && tx_idx == 5'h00)
      |=> (o_tx_valid && o_tx_data == RSP_DEVICES);
  endproperty
  a_dev_first: assert property (p_dev_first)
    else $error("device reply does not open with 30h");

  property p_avail_sum;
    (o_tx_valid && rep == REP_AVAIL && tx_last) |-> o_tx_data == AVAIL_SUM;
  endproperty
  a_avail_sum: assert property (p_avail_sum)
    else $error("availability check byte wrong");

  property p_darea_sum;
    (o_tx_valid && rep == REP_DAREA && tx_last) |-> o_tx_data == DAREA_SUM;
  endproperty
  a_darea_sum: assert property (p_darea_sum)
    else $error("data area check byte wrong");

  property p_dev_ack;
    (frame_end && frame_total == 8'h00 && cmd == CMD_DEVSEL && code_ok)
      |=> (o_tx_data == ACK_DEV && o_dev_selected);
  endproperty
  a_dev_ack: assert property (p_dev_ack)
    else $error("device select not acknowledged");

  property p_bad_sum;
    (frame_end && frame_total != 8'h00)
      |=> (o_tx_data == (cmd | ERR_FLAG) && tx_second == ERR_SUM);
  endproperty
  a_bad_sum: assert property (p_bad_sum)
    else $error("checksum fault not reported");

  property p_rate_err;
    (calc_done && !calc_ok) |=> (o_tx_data == (CMD_FREQ | ERR_FLAG) &&
                                 tx_second == ERR_RATE);
  endproperty
  a_rate_err: assert property (p_rate_err)
    else $error("rate fault not reported with 24h");

  property p_undef;
    (take_cmd && bsi_decode(i_rx_data) == REP_NONE &&
     i_rx_data != CMD_DEVSEL && i_rx_data != CMD_FREQ)
      |=> (o_tx_valid && o_tx_data == RSP_UNDEF &&
           tx_second == $past(i_rx_data));
  endproperty
  a_undef: assert property (p_undef)
    else $error("undefined command reply wrong");

  property p_switch;
    o_rate_switch |-> (st == ST_CONFIRM && o_baud_n != 9'h000);
  endproperty
  a_switch: assert property (p_switch)
    else $error("rate switch without a valid divider");

  c_block:   cover property (o_tx_valid && rep == REP_BLOCK && tx_last);
  c_devsel:  cover property (o_dev_selected && o_big_endian);
  c_switch:  cover property (o_rate_switch);
  c_confirm: cover property (st == ST_CONFIRM ##1 o_tx_data == ACK_OK);

endmodule : bsi_interp

`default_nettype wire

// file: testbench/bsi_host.sv
/*
  Host programmer model: sends command bytes, takes reply bytes.
  Assumes the bench supplies a stall bit updated on each clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module bsi_host
#(
  parameter int OLD_BIT = 1042
)
(
  input  wire logic       i_clk,   // System clock
  input  wire logic       i_stall, // Hold off reply bytes
  output logic            o_valid, // Byte strobe to device
  output logic      [7:0] o_data,  // Byte to device
  output logic            o_err,   // Corrupt byte flag
  output logic            o_ready  // Reply byte taken
);
  initial
  begin
    o_valid = 1'b0;
    o_data  = 8'h00;
    o_err   = 1'b0;
    o_ready = 1'b0;
  end

  always @(posedge i_clk)
  begin
    #1 o_ready = !i_stall;
  end

  task automatic put(input logic [7:0] b, input logic e);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_data  = b;
    o_err   = e;
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    // Released line shows no stale byte
    o_data  = ~b;
    o_err   = ~e;
  endtask : put

  // Code, size, payload, then the check byte; bad spoils the check
  task automatic frame(input logic [127:0] v, input int n, input logic bad);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      s = s - v[127-8*i -: 8];
      put(v[127-8*i -: 8], 1'b0);
    end
    put(s ^ {7'h00, bad}, 1'b0);
  endtask : frame

  task automatic confirm(input logic e);
    repeat (OLD_BIT) @(posedge i_clk);
    put(8'h00, e);
  endtask : confirm
endmodule : bsi_host
`default_nettype wire

// file: testbench/boot_serial_inquiry_setting_test.sv
/*
  Self-checking bench for the command interpreter.
  Assumes the host model drives the receive side and takes replies.
*/
`timescale 1ns/10ps
`default_nettype none

module boot_serial_inquiry_setting_test
  import bsi_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cmd_wait = 1'b1;
  logic        volt_high = 1'b1;
  logic        stall = 1'b0;
  logic        rx_valid, rx_err, tx_valid, tx_ready;
  logic        rate_switch, dev_sel, big_end;
  logic [7:0]  rx_data, tx_data;
  logic [8:0]  baud_n, baud_seen;
  logic [7:0]  exp[$];
  logic [31:0] lfsr = 32'hB3AD3AA7;
  int          err_total = 0;
  int          compares = 0;

  bsi_interp u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_cmd_wait(cmd_wait),
    .i_volt_high(volt_high), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_err(rx_err), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .o_rate_switch(rate_switch), .o_baud_n(baud_n),
    .o_dev_selected(dev_sel), .o_big_endian(big_end));
  bsi_host u_host (.i_clk(clk), .i_stall(stall), .o_valid(rx_valid),
    .o_data(rx_data), .o_err(rx_err), .o_ready(tx_ready));

  always #50 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Random stalls on the reply side
  always @(posedge clk)
  begin
    lfsr  <= lfsr_next(lfsr);
    stall <= lfsr[0] & lfsr[1];
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] want);
    compares++;
    if (seen !== want)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  // Every byte taken is matched against the oldest note
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      chk({1'b0, tx_data}, exp.size() ? {1'b0, exp.pop_front()} : 9'h1FF);
    if (rate_switch === 1'b1)
      baud_seen = baud_n;
  end

  task automatic exp_b(input logic [7:0] b);
    exp.push_back(b);
  endtask : exp_b

  // Fixed check byte when fix is nonzero, else the zero-sum value
  task automatic exp_img(input logic [255:0] v, input int n,
                         input logic [7:0] fix);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      exp_b(v[255-8*i -: 8]);
      s = s - v[255-8*i -: 8];
    end
    exp_b(fix != 8'h00 ? fix : s);
  endtask : exp_img

  task automatic drain(input string t);
    for (int k = 0; k < 3000 && exp.size() != 0; k++)
      @(posedge clk);
    repeat (6) @(posedge clk);
    chk(9'(exp.size()), 9'h000);
    $display("test %s done", t);
  endtask : drain

  task automatic dsel(input logic [31:0] c, input logic bad,
                      input logic [7:0] e);
    if (e == 8'h00)
      exp_b(8'h46);
    else
    begin
      exp_b(8'h90);
      exp_b(e);
    end
    u_host.frame({8'h10, 8'h04, c, 80'h0}, 6, bad);
    drain("device select");
  endtask : dsel

  task automatic freq(input logic [15:0] r, input logic bad,
                      input logic cerr);
    longint rf, n, ok;
    rf = volt_high ? 32000000 : 8000000;
    n = (r == 0) ? 0 : rf / (3200 * r);
    ok = !bad && n >= 1 && n <= 256 && 100 * rf < 104 * 3200 * r * n;
    baud_seen = 'x;
    exp_b(ok ? 8'h06 : 8'hBF);
    if (!ok)
      exp_b(bad ? 8'h11 : 8'h24);
    u_host.frame({8'h3F, 8'h07, r, 16'h0000, 8'h02, 8'h01, 8'h01, 56'h0},
                 9, bad);
    drain("rate select");
    if (ok)
    begin
      chk(baud_seen, n[8:0]);
      exp_b(cerr ? 8'hBF : 8'h06);
      if (cerr)
        exp_b(8'hFF);
      u_host.confirm(cerr);
      drain("confirm");
    end
  endtask : freq

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    #5000000;
    err_total++;
    end_sim();
  end

  initial
  begin
    logic [7:0] u;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1 cmd_wait = 1'b0;
    u_host.put(CMD_AVAIL, 1'b0);
    u_host.frame({8'h10, 8'h04, DEV_CODE_LE, 80'h0}, 6, 1'b0);
    drain("not waiting");
    chk({8'h00, dev_sel}, 9'h000);
    #1 cmd_wait = 1'b1;
    exp_img({RSP_AVAIL, 8'h01, 8'h1D, 232'h0}, 3, 8'hA8);
    u_host.put(CMD_AVAIL, 1'b0);
    drain("availability");
    exp_img({RSP_UAREA, 8'h09, 8'h01, USER_START, USER_END, 168'h0},
            11, 8'h00);
    u_host.put(CMD_UAREA, 1'b0);
    drain("user area");
    exp_img({RSP_DAREA, 8'h09, 8'h01, 32'h0010_0000, 32'h0010_0FFF,
             168'h0}, 11, 8'h8D);
    u_host.put(CMD_DAREA, 1'b0);
    drain("data area");
    exp_img({RSP_BLOCK, 16'h0019, 8'hDD, USER_START, 32'h0000_0400,
             USER_BLOCKS, 32'h0010_0000, 32'h0000_0400, 32'h0000_0004,
             32'h0}, 28, 8'h00);
    u_host.put(CMD_BLOCK, 1'b0);
    drain("block");
    exp_img({8'h30, 8'h13, 8'h02, REC_CHARS, DEV_CODE_LE, NAME_LE, REC_CHARS,
             DEV_CODE_BE, NAME_BE, 88'h0}, 21, 8'h00);
    u_host.put(CMD_DEVICES, 1'b0);
    drain("devices");
    u = {4'h6, lfsr[3:0]};
    exp_b(8'h80);
    exp_b(u);
    u_host.put(u, 1'b0);
    drain("undefined");
    dsel(DEV_CODE_LE, 1'b1, 8'h11);
    dsel(DEV_CODE_LE ^ 32'h0000_0100, 1'b0, 8'h21);
    dsel(DEV_CODE_LE, 1'b0, 8'h00);
    chk({7'h00, dev_sel, big_end}, 9'h002);
    dsel(DEV_CODE_BE, 1'b0, 8'h00);
    chk({7'h00, dev_sel, big_end}, 9'h003);
    freq(16'(19200 / 100), 1'b0, 1'b0);
    freq(16'h1D4C, 1'b0, 1'b0);
    freq(16'h00C0, 1'b1, 1'b0);
    freq(16'h00C0, 1'b0, 1'b1);
    freq({6'h00, lfsr[9:0]}, 1'b0, 1'b0);
    #1 volt_high = 1'b0;
    repeat (6) @(posedge clk);
    freq(16'h000A, 1'b0, 1'b0);
    freq(16'h0009, 1'b0, 1'b0);
    end_sim();
  end
endmodule : boot_serial_inquiry_setting_test
`default_nettype wire
